//--- src/src_ctrl_map.svh
// Register map, field positions and timing counts of the rate converter control
// Functional notes
// - Output PDM data delayed by selector: none, 14 ns, 20 ns, 26 ns; all three round up to one 100 ns hclk cycle.
// - Output channel selector: 00 off, 01 right on fall, 10 left on rise, 11 both.
// - Input PDM data delayed by selector: none, 6 ns, 12 ns, 18 ns; all three round up to one 100 ns hclk cycle.
// - Output flow clear bit clears output flags and blocks new ones while set.
// - Input flow clear bit clears input flags and blocks new ones while set.
// - Output underrun and overrun flags set on their path events.
// - Input underrun and overrun flags set on their path events.
// - Restart lock write restarts rate synchronisation; bit reads zero.
// - Output lock reads 0 acquiring, 1 ready; always 1 in manual mode.
// - Output filter setting 00 48k, 01 96k, 11 192k; 10 reserved.
// - Output filter bypass bit removes the output upsampling filter.
// - Output conversion mode bit: 0 manual, 1 automatic.
// - Dither applied when dither-off bit is zero, omitted when one.
// - Input lock reads 0 while acquiring and 1 once ready.
// - Input filter setting 00 48k, 01 96k, 11 192k; 10 reserved.
// - Input filter bypass bit removes the input upsampling filter.
// - Input conversion mode bit: 0 manual, 1 automatic.
// - One enable bit switches both conversion paths on or off.
// - Manual mode accepts rate word writes at any time and uses them.
// - Automatic mode returns measured input rate once input lock is ready.
`ifndef SRC_CTRL_MAP_SVH
`define SRC_CTRL_MAP_SVH
`define CTRL_ADDR       32'h5000_4000
`define RATE_ADDR       32'h5000_4004
`define CTRL_RESET      32'h0000_0000
`define RATE_RESET      24'h00_0000
`define F_OUT_DLY       31:30
`define F_OUT_CHAN      29:28
`define F_IN_DLY        27:26
`define B_OUT_CLR       25
`define B_IN_CLR        24
`define B_OUT_UNDER     23
`define B_OUT_OVER      22
`define B_IN_UNDER      21
`define B_IN_OVER       20
`define B_RESTART       19
`define B_OUT_LOCK      18
`define F_OUT_FILT      17:16
`define B_OUT_BYP       14
`define B_OUT_AUTO      13
`define B_DITHER_OFF    7
`define B_IN_LOCK       6
`define F_IN_FILT       5:4
`define B_IN_BYP        2
`define B_IN_AUTO       1
`define B_ENABLE        0
`define F_RATE          23:0
`define FILT_RESERVED   2'h2
`define HCLK_PERIOD_NS  100
`define OUT_DLY1_NS     14
`define OUT_DLY2_NS     20
`define OUT_DLY3_NS     26
`define IN_DLY1_NS      6
`define IN_DLY2_NS      12
`define IN_DLY3_NS      18
`define NS2CYC(ns)      (((ns) + `HCLK_PERIOD_NS - 1) / `HCLK_PERIOD_NS)
`endif

//--- src/src_ctrl_pkg.sv
// Types shared by the rate converter control modules
package src_ctrl_pkg;
   typedef enum logic [1:0] {LK_IDLE, LK_ACQ, LK_LOCK} lock_state_t;

   typedef struct packed {
      lock_state_t st;
      logic        done;
   } lock_reg_t;

   typedef struct packed {
      logic        ph_act;
      logic        ph_wr;
      logic        ph_ctrl;
      logic        ph_rate;
      logic        rd_wait;
      logic [31:0] rdata;
      logic [31:0] ctrl;
      logic [23:0] rate;
      logic        restart;
      logic        clk_prev;
      logic        dout;
      logic        dout_oe;
      logic        in_left;
      logic        in_right;
   } main_reg_t;
endpackage

//--- src/pdm_delay_line.sv
// Selectable delay line for one PDM data bit
`timescale 1ns/10ps
module pdm_delay_line #(
   parameter int TAP1 = 1,
   parameter int TAP2 = 1,
   parameter int TAP3 = 1,
   parameter int DEPTH = 4
) (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [1:0] sel,
   input  wire logic       din,
   output logic            dout
);
   logic [DEPTH-1:0] sr_r;
   logic [DEPTH-1:0] sr_nxt;

   always_comb begin
      sr_nxt = {sr_r[DEPTH-2:0], din};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sr_r <= '0;
      end else begin
         sr_r <= sr_nxt;
      end
   end

   // Delays below one period still cost a whole cycle
   always_comb begin
      case (sel)
         2'h0:    dout = din;
         2'h1:    dout = sr_r[TAP1-1];
         2'h2:    dout = sr_r[TAP2-1];
         2'h3:    dout = sr_r[TAP3-1];
         default: dout = din;
      endcase
   end

   tap_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sel == 2'h1 |-> dout == $past(din, TAP1)) else $error("delay tap wrong");
endmodule

//--- src/lock_tracker.sv
// Rate acquisition tracker for one conversion path
`timescale 1ns/10ps
module lock_tracker (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic enable,
   input  wire logic auto_mode,
   input  wire logic restart,
   input  wire logic meas_done,
   output logic      ready,
   output logic      locked_pulse
);
   src_ctrl_pkg::lock_reg_t s_r;
   src_ctrl_pkg::lock_reg_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      case (s_r.st)
         src_ctrl_pkg::LK_IDLE: begin
            if (enable) begin
               s_nxt.st = auto_mode ? src_ctrl_pkg::LK_ACQ : src_ctrl_pkg::LK_LOCK;
            end
         end
         src_ctrl_pkg::LK_ACQ: begin
            if (!auto_mode) begin
               s_nxt.st = src_ctrl_pkg::LK_LOCK;
            end else if (meas_done) begin
               s_nxt.st = src_ctrl_pkg::LK_LOCK;
               s_nxt.done = 1'b1;
            end
         end
         src_ctrl_pkg::LK_LOCK: begin
            if (auto_mode && restart) begin
               s_nxt.st = src_ctrl_pkg::LK_ACQ;
            end
         end
         default: s_nxt.st = src_ctrl_pkg::LK_IDLE;
      endcase
      if (!enable) begin
         s_nxt.st = src_ctrl_pkg::LK_IDLE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '{st: src_ctrl_pkg::LK_IDLE, done: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ready = (s_r.st == src_ctrl_pkg::LK_LOCK);
   assign locked_pulse = s_r.done;

   restart_acq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      enable && auto_mode && restart && ready |=> !ready) else $error("restart kept lock");
endmodule

//--- src/src_ctrl.sv
// AHB-Lite register block and PDM pin logic of the audio rate converter
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "src_ctrl_map.svh"
module src_ctrl (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        pdm_bit_clock,
   input  wire logic        pdm_data_in,
   output logic             pdm_data_out,
   output logic             pdm_data_out_oe,
   input  wire logic        out_left_bit,
   input  wire logic        out_right_bit,
   output logic             in_left_bit,
   output logic             in_right_bit,
   input  wire logic        out_underrun_evt,
   input  wire logic        out_overrun_evt,
   input  wire logic        in_underrun_evt,
   input  wire logic        in_overrun_evt,
   input  wire logic        in_meas_done,
   input  wire logic [23:0] in_rate_measured,
   input  wire logic        out_meas_done,
   output logic             converter_enable,
   output logic             in_auto_conversion,
   output logic             out_auto_conversion,
   output logic [1:0]       in_filter_setting,
   output logic [1:0]       out_filter_setting,
   output logic             in_filter_bypass,
   output logic             out_filter_bypass,
   output logic             dither_on,
   output logic [23:0]      in_rate_word,
   output logic             restart_lock
);
   // ******************************************************************
   // State and helpers
   // ******************************************************************
   src_ctrl_pkg::main_reg_t s_r;
   src_ctrl_pkg::main_reg_t s_nxt;
   logic                    in_ready;
   logic                    out_ready;
   logic                    in_locked;
   logic                    out_lock_ready;
   logic                    in_lock_ready;
   logic                    wr_now;
   logic                    addr_ok;
   logic                    clk_rise;
   logic                    clk_fall;
   logic                    din_dly;
   logic                    dout_dly;
   logic [31:0]             rd_mux;

   assign addr_ok = hsel && htrans[1] && hready;
   assign wr_now = s_r.ph_act && s_r.ph_wr;
   assign clk_rise = pdm_bit_clock && !s_r.clk_prev;
   assign clk_fall = !pdm_bit_clock && s_r.clk_prev;
   assign out_lock_ready = !s_r.ctrl[`B_OUT_AUTO] || out_ready;
   assign in_lock_ready = in_ready;

   // ******************************************************************
   // Read view
   // ******************************************************************
   // Clear and restart bits are write-only and read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (s_r.ph_ctrl) begin
         rd_mux = s_r.ctrl;
         rd_mux[`B_OUT_CLR] = 1'b0;
         rd_mux[`B_IN_CLR] = 1'b0;
         rd_mux[`B_RESTART] = 1'b0;
         rd_mux[`B_OUT_LOCK] = out_lock_ready;
         rd_mux[`B_IN_LOCK] = in_lock_ready;
      end else if (s_r.ph_rate) begin
         rd_mux[`F_RATE] = s_r.rate;
      end
   end

   // ******************************************************************
   // Next state
   // ******************************************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.restart = 1'b0;
      // Bus data phase ends here unless a read still waits
      if (s_r.ph_act && s_r.rd_wait) begin
         s_nxt.rdata = rd_mux;
         s_nxt.rd_wait = 1'b0;
      end else begin
         s_nxt.ph_act = addr_ok;
         s_nxt.ph_wr = hwrite;
         s_nxt.ph_ctrl = (haddr == `CTRL_ADDR);
         s_nxt.ph_rate = (haddr == `RATE_ADDR);
         s_nxt.rd_wait = addr_ok && !hwrite;
      end
      if (wr_now && s_r.ph_ctrl) begin
         s_nxt.ctrl[`F_OUT_DLY] = hwdata[`F_OUT_DLY];
         s_nxt.ctrl[`F_OUT_CHAN] = hwdata[`F_OUT_CHAN];
         s_nxt.ctrl[`F_IN_DLY] = hwdata[`F_IN_DLY];
         s_nxt.ctrl[`B_OUT_CLR] = hwdata[`B_OUT_CLR];
         s_nxt.ctrl[`B_IN_CLR] = hwdata[`B_IN_CLR];
         s_nxt.restart = hwdata[`B_RESTART];
         // A reserved filter code leaves the setting as it was
         if (hwdata[`F_OUT_FILT] != `FILT_RESERVED) begin
            s_nxt.ctrl[`F_OUT_FILT] = hwdata[`F_OUT_FILT];
         end
         if (hwdata[`F_IN_FILT] != `FILT_RESERVED) begin
            s_nxt.ctrl[`F_IN_FILT] = hwdata[`F_IN_FILT];
         end
         s_nxt.ctrl[`B_OUT_BYP] = hwdata[`B_OUT_BYP];
         s_nxt.ctrl[`B_OUT_AUTO] = hwdata[`B_OUT_AUTO];
         s_nxt.ctrl[`B_DITHER_OFF] = hwdata[`B_DITHER_OFF];
         s_nxt.ctrl[`B_IN_BYP] = hwdata[`B_IN_BYP];
         s_nxt.ctrl[`B_IN_AUTO] = hwdata[`B_IN_AUTO];
         s_nxt.ctrl[`B_ENABLE] = hwdata[`B_ENABLE];
      end
      if (wr_now && s_r.ph_rate) begin
         s_nxt.rate = hwdata[`F_RATE];
      end
      // The measured rate wins over a write landing in the same cycle
      if (in_locked && s_r.ctrl[`B_IN_AUTO]) begin
         s_nxt.rate = in_rate_measured;
      end
      // Flow flags: a held clear bit beats any event
      s_nxt.ctrl[`B_OUT_UNDER] = s_r.ctrl[`B_OUT_UNDER] | out_underrun_evt;
      s_nxt.ctrl[`B_OUT_OVER] = s_r.ctrl[`B_OUT_OVER] | out_overrun_evt;
      s_nxt.ctrl[`B_IN_UNDER] = s_r.ctrl[`B_IN_UNDER] | in_underrun_evt;
      s_nxt.ctrl[`B_IN_OVER] = s_r.ctrl[`B_IN_OVER] | in_overrun_evt;
      if (s_r.ctrl[`B_OUT_CLR]) begin
         s_nxt.ctrl[`B_OUT_UNDER] = 1'b0;
         s_nxt.ctrl[`B_OUT_OVER] = 1'b0;
      end
      if (s_r.ctrl[`B_IN_CLR]) begin
         s_nxt.ctrl[`B_IN_UNDER] = 1'b0;
         s_nxt.ctrl[`B_IN_OVER] = 1'b0;
      end
      // Output pin: right bit at falling edge, left bit at rising edge
      s_nxt.clk_prev = pdm_bit_clock;
      s_nxt.dout_oe = (s_r.ctrl[`F_OUT_CHAN] != 2'h0);
      if (clk_fall && s_r.ctrl[`B_OUT_CLR - 25 + 28]) begin
         s_nxt.dout = out_right_bit;
      end
      if (clk_rise && s_r.ctrl[`B_OUT_CLR - 25 + 29]) begin
         s_nxt.dout = out_left_bit;
      end
      if (clk_rise) begin
         s_nxt.in_left = din_dly;
      end
      if (clk_fall) begin
         s_nxt.in_right = din_dly;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ******************************************************************
   // Sub-blocks
   // ******************************************************************
   lock_tracker u_in_lock (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .enable       (s_r.ctrl[`B_ENABLE]),
      .auto_mode    (s_r.ctrl[`B_IN_AUTO]),
      .restart      (s_r.restart),
      .meas_done    (in_meas_done),
      .ready        (in_ready),
      .locked_pulse (in_locked)
   );

   lock_tracker u_out_lock (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .enable       (s_r.ctrl[`B_ENABLE]),
      .auto_mode    (s_r.ctrl[`B_OUT_AUTO]),
      .restart      (s_r.restart),
      .meas_done    (out_meas_done),
      .ready        (out_ready),
      .locked_pulse ()
   );

   pdm_delay_line #(
      .TAP1  (`NS2CYC(`OUT_DLY1_NS)),
      .TAP2  (`NS2CYC(`OUT_DLY2_NS)),
      .TAP3  (`NS2CYC(`OUT_DLY3_NS)),
      .DEPTH (4)
   ) u_out_dly (
      .hclk    (hclk),
      .hresetn (hresetn),
      .sel     (s_r.ctrl[`F_OUT_DLY]),
      .din     (s_r.dout),
      .dout    (dout_dly)
   );

   pdm_delay_line #(
      .TAP1  (`NS2CYC(`IN_DLY1_NS)),
      .TAP2  (`NS2CYC(`IN_DLY2_NS)),
      .TAP3  (`NS2CYC(`IN_DLY3_NS)),
      .DEPTH (4)
   ) u_in_dly (
      .hclk    (hclk),
      .hresetn (hresetn),
      .sel     (s_r.ctrl[`F_IN_DLY]),
      .din     (pdm_data_in),
      .dout    (din_dly)
   );

   // ******************************************************************
   // Outputs
   // ******************************************************************
   assign hreadyout = !(s_r.ph_act && s_r.rd_wait);
   assign hrdata = s_r.rdata;
   assign hresp = 1'b0;
   assign pdm_data_out = dout_dly;
   assign pdm_data_out_oe = s_r.dout_oe;
   assign in_left_bit = s_r.in_left;
   assign in_right_bit = s_r.in_right;
   assign converter_enable = s_r.ctrl[`B_ENABLE];
   assign in_auto_conversion = s_r.ctrl[`B_IN_AUTO];
   assign out_auto_conversion = s_r.ctrl[`B_OUT_AUTO];
   assign in_filter_setting = s_r.ctrl[`F_IN_FILT];
   assign out_filter_setting = s_r.ctrl[`F_OUT_FILT];
   assign in_filter_bypass = s_r.ctrl[`B_IN_BYP];
   assign out_filter_bypass = s_r.ctrl[`B_OUT_BYP];
   assign dither_on = !s_r.ctrl[`B_DITHER_OFF];
   assign in_rate_word = s_r.rate;
   assign restart_lock = s_r.restart;

   // ******************************************************************
   // Checks
   // ******************************************************************
   out_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.ctrl[`B_OUT_CLR] |=> !s_r.ctrl[`B_OUT_UNDER] && !s_r.ctrl[`B_OUT_OVER])
      else $error("output flags survived clear");
   in_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.ctrl[`B_IN_CLR] |=> !s_r.ctrl[`B_IN_UNDER] && !s_r.ctrl[`B_IN_OVER])
      else $error("input flags survived clear");
   out_flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      out_underrun_evt && !s_r.ctrl[`B_OUT_CLR] |=> s_r.ctrl[`B_OUT_UNDER])
      else $error("output underrun lost");
   in_flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      in_overrun_evt && !s_r.ctrl[`B_IN_CLR] |=> s_r.ctrl[`B_IN_OVER])
      else $error("input overrun lost");
   manual_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.rd_wait && s_r.ph_ctrl && !out_auto_conversion |=> hrdata[`B_OUT_LOCK])
      else $error("manual lock low");
   auto_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      in_locked && in_auto_conversion |=> in_rate_word == $past(in_rate_measured))
      else $error("measured rate not loaded");
   chan_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.ctrl[`F_OUT_CHAN] == 2'h0 |=> !pdm_data_out_oe) else $error("pin driven");
   ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_now && s_r.ph_ctrl |=> converter_enable == $past(hwdata[`B_ENABLE])
      && dither_on == !$past(hwdata[`B_DITHER_OFF])) else $error("ctrl write lost");
   read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_ok && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read timing");

   flag_cover: cover property (@(posedge hclk) disable iff (!hresetn)
      s_r.ctrl[`B_OUT_UNDER] ##1 s_r.ctrl[`B_OUT_CLR]);
   lock_cover: cover property (@(posedge hclk) disable iff (!hresetn)
      in_auto_conversion && in_locked);
   both_cover: cover property (@(posedge hclk) disable iff (!hresetn)
      s_r.ctrl[`F_OUT_CHAN] == 2'h3 && clk_fall);
endmodule

//--- verification/pdm_far_side.sv
// Far-side model: PDM microphone and speaker pins plus the audio path events
`timescale 1ns/10ps
module pdm_far_side (
   input  wire logic   hclk,
   output logic        pdm_bit_clock,
   output logic        pdm_data_in,
   output logic        out_left_bit,
   output logic        out_right_bit,
   output logic [3:0]  flow_evt,
   output logic        in_meas_done,
   output logic        out_meas_done,
   output logic [23:0] in_rate_measured
);
   logic framing;

   initial begin
      {pdm_bit_clock, pdm_data_in, out_left_bit, out_right_bit} = 4'h0;
      {flow_evt, in_meas_done, out_meas_done} = 6'h0;
      in_rate_measured = 24'h0;
      framing = 1'b0;
   end

   // Released data line toggles every cycle so a stale bit never passes for a capture;
   // it moves off the sampling edge so it never meets a frame's own drive
   always @(negedge hclk) begin
      if (!framing) begin
         pdm_data_in <= ~pdm_data_in;
      end
   end

   // One half bit period; data settles one cycle before the clock moves, so a delayed
   // input still captures it; the clock stands still between frames
   task automatic half_bit(input int hold, input logic l, input logic r, input logic d);
      framing = 1'b1;
      out_left_bit <= l;
      out_right_bit <= r;
      pdm_data_in <= d;
      @(posedge hclk);
      pdm_bit_clock <= ~pdm_bit_clock;
      repeat (hold) @(posedge hclk);
   endtask

   task automatic idle();
      framing = 1'b0;
   endtask

   task automatic pulse(input logic [3:0] e);
      flow_evt <= e;
      @(posedge hclk);
      flow_evt <= 4'h0;
   endtask

   // Measured word is 8192 * rate / 100, rate kept at or below 192 kHz
   task automatic meas(input int rate_hz);
      in_rate_measured <= 24'(8192 * rate_hz / 100);
      in_meas_done <= 1'b1;
      out_meas_done <= 1'b1;
      @(posedge hclk);
      in_meas_done <= 1'b0;
      out_meas_done <= 1'b0;
   endtask
endmodule

//--- verification/test_audio_sample_rate_converter_ctrl.sv
// Self-checking testbench of the rate converter control block
`timescale 1ns/10ps
`include "src_ctrl_map.svh"
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin miscompares++; \
   $display("wrong value at %0t: %h vs %h", $time, act, exp); end end
module test_audio_sample_rate_converter_ctrl;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, restart_lock;
   logic        pdm_bit_clock, pdm_data_in, pdm_data_out, pdm_data_out_oe;
   logic        out_left_bit, out_right_bit, in_left_bit, in_right_bit;
   logic        in_meas_done, out_meas_done, converter_enable, dither_on;
   logic        in_auto_conversion, out_auto_conversion, in_filter_bypass, out_filter_bypass;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans, in_filter_setting, out_filter_setting;
   logic [2:0]  hsize;
   logic [3:0]  flow_evt;
   logic [23:0] in_rate_measured, in_rate_word;
   int          miscompares, cmp_count, n0, n;
   int          restart_cnt = 0;

   src_ctrl i_src_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pdm_bit_clock, .pdm_data_in,
      .pdm_data_out, .pdm_data_out_oe, .out_left_bit, .out_right_bit, .in_left_bit,
      .in_right_bit, .out_underrun_evt(flow_evt[3]), .out_overrun_evt(flow_evt[2]),
      .in_underrun_evt(flow_evt[1]), .in_overrun_evt(flow_evt[0]), .in_meas_done,
      .in_rate_measured, .out_meas_done, .converter_enable, .in_auto_conversion,
      .out_auto_conversion, .in_filter_setting, .out_filter_setting, .in_filter_bypass,
      .out_filter_bypass, .dither_on, .in_rate_word, .restart_lock);

   pdm_far_side i_pdm_far_side (.hclk, .pdm_bit_clock, .pdm_data_in, .out_left_bit,
      .out_right_bit, .flow_evt, .in_meas_done, .out_meas_done, .in_rate_measured);

   // ****************************************
   // Clock, monitors and bus tasks
   // ****************************************
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      if (restart_lock === 1'b1) begin
         restart_cnt++;
      end
   end

   // Ready is judged mid-cycle, where it is settled until the edge that samples it;
   // no wait is bounded here, a hang is ended by the watchdog
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      @(posedge hclk);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      rd(`CTRL_ADDR, q);
      `CHK(q, `CTRL_RESET | (32'h1 << `B_OUT_LOCK))
      rd(`RATE_ADDR, q);
      `CHK(q, {8'h00, `RATE_RESET})
      `CHK(dither_on, 1'b1)
      wr(32'h5000_4008, 32'hffff_ffff);
      rd(32'h5000_4008, q);
      `CHK(q, 32'h0000_0000)
   endtask

   task automatic t_config();
      logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
      wr(`CTRL_ADDR, 32'h0b03_4095);
      @(negedge hclk);
      `CHK({converter_enable, out_filter_setting, in_filter_setting}, 5'h1d)
      `CHK({out_filter_bypass, in_filter_bypass, dither_on}, 3'h6)
      `CHK({out_auto_conversion, in_auto_conversion}, 2'h0)
      rd(`CTRL_ADDR, q);
      `CHK(q, 32'h0807_40d5)
      wr(`RATE_ADDR, 32'hff3c_0000);
      rd(`RATE_ADDR, q);
      `CHK(q, 32'h003c_0000)
      `CHK(in_rate_word, 24'h3c_0000)
      // Reserved filter code must leave both fields as they were
      wr(`CTRL_ADDR, 32'h0802_2023);
      @(negedge hclk);
      `CHK({out_filter_setting, in_filter_setting}, 4'hd)
      `CHK({out_auto_conversion, in_auto_conversion, dither_on}, 3'h7)
      `CHK({out_filter_bypass, in_filter_bypass}, 2'h0)
      rd(`CTRL_ADDR, q);
      `CHK(q & 32'hfffb_ffbf, 32'h0803_2013)
      foreach (codes[i]) begin
         wr(`CTRL_ADDR, {14'h0, codes[i], 10'h0, codes[i], 4'h1});
         @(negedge hclk);
         `CHK(out_filter_setting, codes[i])
         `CHK(in_filter_setting, codes[i])
      end
      wr(`CTRL_ADDR, 32'h0000_0000);
      @(negedge hclk);
      `CHK(converter_enable, 1'b0)
   endtask

   task automatic t_flags();
      wr(`CTRL_ADDR, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         i_pdm_far_side.pulse(4'(1 << i));
         rd(`CTRL_ADDR, q);
         `CHK(q[23:20], 4'((2 << i) - 1))
      end
      wr(`CTRL_ADDR, 32'h0200_0001);
      i_pdm_far_side.pulse(4'hf);
      rd(`CTRL_ADDR, q);
      `CHK(q[25:20], 6'h03)
      wr(`CTRL_ADDR, 32'h0300_0001);
      i_pdm_far_side.pulse(4'hf);
      rd(`CTRL_ADDR, q);
      `CHK(q[25:20], 6'h00)
      wr(`CTRL_ADDR, 32'h0000_0001);
      i_pdm_far_side.pulse(4'h4);
      rd(`CTRL_ADDR, q);
      `CHK(q[23:20], 4'h4)
   endtask

   task automatic t_lock();
      int c;
      wr(`CTRL_ADDR, 32'h0000_0001);
      rd(`CTRL_ADDR, q);
      `CHK({q[18], q[6]}, 2'h3)
      wr(`CTRL_ADDR, 32'h0000_0000);
      wr(`CTRL_ADDR, 32'h0000_2013);
      rd(`CTRL_ADDR, q);
      `CHK({q[18], q[6]}, 2'h0)
      i_pdm_far_side.meas(96000);
      rd(`CTRL_ADDR, q);
      `CHK({q[18], q[6]}, 2'h3)
      rd(`RATE_ADDR, q);
      `CHK(q, 32'h0078_0000)
      `CHK(in_rate_word, 24'h78_0000)
      c = restart_cnt;
      wr(`CTRL_ADDR, 32'h0008_2013);
      rd(`CTRL_ADDR, q);
      `CHK({q[19], q[18], q[6]}, 3'h0)
      `CHK(restart_cnt - c, 1)
   endtask

   // Cycles from a rising bit clock to the left bit on the pin, both channels driven
   task automatic lat(input logic [1:0] dly, output int k);
      wr(`CTRL_ADDR, {dly, 2'h3, 2'h3, 26'h1});
      if (pdm_bit_clock !== 1'b1) i_pdm_far_side.half_bit(6, 1'b1, 1'b0, 1'b0);
      i_pdm_far_side.half_bit(6, 1'b0, 1'b0, 1'b0);
      `CHK(pdm_data_out, 1'b0)
      i_pdm_far_side.half_bit(0, 1'b1, 1'b0, 1'b1);
      k = 0;
      do begin @(negedge hclk); k++; end while (pdm_data_out !== 1'b1 && k < 10);
      @(posedge hclk);
   endtask

   task automatic tog(input logic l, input logic r, input logic d, input logic exp);
      i_pdm_far_side.half_bit(6, l, r, d);
      @(negedge hclk);
      `CHK(pdm_data_out, exp)
      `CHK(pdm_data_out_oe, 1'b1)
      if (pdm_bit_clock) `CHK(in_left_bit, d)
      else `CHK(in_right_bit, d)
      @(posedge hclk);
   endtask

   task automatic t_pdm();
      lat(2'h0, n0);
      `CHK(n0 < 5, 1'b1)
      for (int k = 1; k < 4; k++) begin
         lat(2'(k), n);
         `CHK(n - n0, 1)
      end
      wr(`CTRL_ADDR, 32'h1000_0001);
      tog(1'b0, 1'b0, 1'b0, 1'b0);
      tog(1'b1, 1'b1, 1'b1, 1'b0);
      wr(`CTRL_ADDR, 32'h2c00_0001);
      tog(1'b0, 1'b1, 1'b0, 1'b0);
      tog(1'b1, 1'b0, 1'b1, 1'b1);
      wr(`CTRL_ADDR, 32'h0000_0001);
      // Enable follows the stored channel field one cycle later
      repeat (2) @(negedge hclk);
      `CHK(pdm_data_out_oe, 1'b0)
      i_pdm_far_side.idle();
   endtask

   // ****************************************
   // Sequence, watchdog and verdict
   // ****************************************
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Whole sequence needs well under a thousand cycles; allow generous slack
   initial begin
      repeat (8000) @(posedge hclk);
      miscompares++;
      complete_run();
   end

   initial begin
      {hresetn, hsel, hwrite, htrans} = 5'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      miscompares = 0;
      cmp_count = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_config();
      t_flags();
      t_lock();
      t_pdm();
      complete_run();
   end
endmodule
